// ===== rtl/bsd_pkg.sv
// Package of types and constants for the shifter and saturating double-add datapath
package bsd_pkg;

  localparam int unsigned DATA_W = 32;
  localparam int unsigned LEN_W = 8;
  localparam int unsigned ADDR_W = 8;

  // Shift-length limits for immediate forms
  localparam logic [LEN_W-1:0] LEN_MAX_RIGHT = 8'h20;
  localparam logic [LEN_W-1:0] LEN_MAX_LEFT_ROT = 8'h1F;
  localparam logic [LEN_W-1:0] LEN_WORD = 8'h20;

  // Register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] OFF_FLAGS = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_LAST_RESULT = 8'h0C;

  // Field positions
  localparam int unsigned FLAG_CARRY_BIT = 0;
  localparam int unsigned FLAG_SAT_BIT = 1;
  localparam int unsigned EV_SAT_BIT = 0;
  localparam int unsigned EV_BADLEN_BIT = 1;
  localparam int unsigned EV_W = 2;

  // Reset values
  localparam logic [1:0] FLAGS_RST = 2'h0;
  localparam logic [EV_W-1:0] IRQ_STATUS_RST = 2'h0;
  localparam logic [EV_W-1:0] IRQ_MASK_RST = 2'h0;

  // Signed saturation bounds
  localparam logic [DATA_W-1:0] SAT_MAX = 32'h7FFFFFFF;
  localparam logic [DATA_W-1:0] SAT_MIN = 32'h80000000;

  typedef enum logic [1:0] {
    BSD_OP_SHIFT,
    BSD_OP_DADD,
    BSD_OP_DSUB
  } bsd_op_e;

  typedef enum logic [2:0] {
    BSD_SH_LSL,
    BSD_SH_LSR,
    BSD_SH_ASR,
    BSD_SH_ROR,
    BSD_SH_RRX
  } bsd_shift_e;

  typedef struct packed {
    logic valid;
    bsd_op_e op;
    bsd_shift_e shift_type;
    logic [LEN_W-1:0] shift_len;
    logic imm_len;
    logic set_flags;
    logic standalone;
    logic [DATA_W-1:0] src_a;
    logic [DATA_W-1:0] src_b;
  } bsd_req_s;

  typedef struct packed {
    logic valid;
    logic dest_we;
    logic operand_valid;
    logic [DATA_W-1:0] data;
  } bsd_rsp_s;

endpackage : bsd_pkg

// ===== rtl/bsd_datapath.sv
// Barrel shifter and saturating double-add/subtract slice with flags and register port
// Operation
// - Right shifts accept length 1-32; left shift and rotate accept 1-31.
// - No shift or left shift by zero passes the source value through unchanged.
// - Only the shifted copy feeds the operation; the source register stays intact.
// - Standalone shifts write a destination; operand shifts go to the consumer.
// - Every flag-setting shift updates carry, except a shift of length zero other than rotate right with extend.
// - Arithmetic right shift fills vacated top bits with the original sign bit.
// - Arithmetic right shift equals division by power of two, rounded down.
// - Flag-setting arithmetic right shift puts last bit shifted out into carry.
// - Arithmetic right shift by 32 or more gives all bits equal to bit 31.
// - Such a shift updating carry loads carry with original bit 31.
// - Logical right shift clears the vacated top bits to zero.
// - Rotate right with extend rotates one bit through the carry flag.
// - Double-add: saturate doubled second operand, add first, saturate, write.
// - Double-sub: saturate doubled second operand, subtract from first, saturate.
// - Doubling and add/sub each clamp to the signed 32-bit range.
// - Any clamp sets the sticky saturation flag; otherwise it stays unchanged.
`timescale 1ns/1ps

module bsd_datapath (
  input wire logic clk,
  input wire logic rst,
  input wire bsd_pkg::bsd_req_s req,
  output bsd_pkg::bsd_rsp_s rsp,
  output logic [1:0] program_status_flags,
  input wire logic [bsd_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [bsd_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [bsd_pkg::DATA_W-1:0] reg_rdata,
  output logic irq
);
  import bsd_pkg::*;

  // Returns {update, carry, result}
  function automatic logic [DATA_W+1:0] shift_f(
    input bsd_shift_e kind,
    input logic [DATA_W-1:0] a,
    input logic [LEN_W-1:0] len,
    input logic cin
  );
    logic [2*DATA_W-1:0] w;
    logic [DATA_W-1:0] res;
    logic c;
    logic upd;
    w = '0;
    res = a;
    c = cin;
    upd = 1'b0;
    if (kind == BSD_SH_RRX) begin
      res = {cin, a[DATA_W-1:1]};
      c = a[0];
      upd = 1'b1;
    end else if (len != '0) begin
      upd = 1'b1;
      unique case (kind)
        BSD_SH_LSL: begin
          if (len < LEN_WORD) begin
            w = {32'h0, a} << len[4:0];
            res = w[DATA_W-1:0];
            c = w[DATA_W];
          end else begin
            res = '0;
            c = (len == LEN_WORD) ? a[0] : 1'b0;
          end
        end
        BSD_SH_LSR: begin
          if (len < LEN_WORD) begin
            w = {a, 32'h0} >> len[4:0];
            res = w[2*DATA_W-1:DATA_W];
            c = w[DATA_W-1];
          end else begin
            res = '0;
            c = (len == LEN_WORD) ? a[DATA_W-1] : 1'b0;
          end
        end
        BSD_SH_ASR: begin
          if (len < LEN_WORD) begin
            // Signed shift keeps the floor-division meaning for negatives
            w = $signed({a, 32'h0}) >>> len[4:0];
            res = w[2*DATA_W-1:DATA_W];
            c = w[DATA_W-1];
          end else begin
            res = {DATA_W{a[DATA_W-1]}};
            c = a[DATA_W-1];
          end
        end
        BSD_SH_ROR: begin
          if (len[4:0] == 5'h00) begin
            res = a;
            c = a[DATA_W-1];
          end else begin
            w = {a, a} >> len[4:0];
            res = w[DATA_W-1:0];
            c = w[DATA_W-1];
          end
        end
        default: begin
          res = a;
          c = cin;
        end
      endcase
    end
    return {upd, c, res};
  endfunction : shift_f

  // Returns {clamped, value}
  function automatic logic [DATA_W:0] sat_f(input logic [DATA_W:0] v);
    logic [DATA_W:0] r;
    r = {1'b0, v[DATA_W-1:0]};
    if (v[DATA_W] != v[DATA_W-1]) begin
      r = {1'b1, v[DATA_W] ? SAT_MIN : SAT_MAX};
    end
    return r;
  endfunction : sat_f

  logic carry_q;
  logic carry_d;
  logic sat_q;
  logic sat_d;
  logic [EV_W-1:0] irq_status_q;
  logic [EV_W-1:0] irq_status_d;
  logic [EV_W-1:0] irq_mask_q;
  logic [DATA_W-1:0] last_result_q;
  logic [DATA_W-1:0] rdata_q;
  bsd_rsp_s rsp_q;
  bsd_rsp_s rsp_d;

  // Shift path
  wire logic [DATA_W+1:0] sh_out = shift_f(req.shift_type, req.src_a, req.shift_len, carry_q);
  wire logic sh_upd = sh_out[DATA_W+1];
  wire logic sh_carry = sh_out[DATA_W];
  wire logic [DATA_W-1:0] sh_res = sh_out[DATA_W-1:0];
  wire logic is_shift = req.valid && (req.op == BSD_OP_SHIFT);
  wire logic carry_wr_hw = is_shift && req.set_flags && sh_upd;

  // Immediate lengths outside the legal range are still executed, but flagged
  wire logic right_kind = (req.shift_type == BSD_SH_LSR) || (req.shift_type == BSD_SH_ASR);
  wire logic left_kind = (req.shift_type == BSD_SH_LSL) || (req.shift_type == BSD_SH_ROR);
  wire logic len_bad = req.imm_len &&
    ((right_kind && req.shift_len > LEN_MAX_RIGHT) ||
     (left_kind && req.shift_len > LEN_MAX_LEFT_ROT));
  wire logic ev_badlen = is_shift && len_bad;

  // Saturating double then add or subtract
  wire logic [DATA_W:0] dbl_sat = sat_f({req.src_b, 1'b0});
  wire logic [DATA_W-1:0] dbl_val = dbl_sat[DATA_W-1:0];
  wire logic [DATA_W:0] ext_a = {req.src_a[DATA_W-1], req.src_a};
  wire logic [DATA_W:0] ext_d = {dbl_val[DATA_W-1], dbl_val};
  wire logic is_dadd = req.valid && (req.op == BSD_OP_DADD);
  wire logic is_dsub = req.valid && (req.op == BSD_OP_DSUB);
  wire logic [DATA_W:0] raw_sum = ext_a + ext_d;
  wire logic [DATA_W:0] raw_dif = ext_a - ext_d;
  wire logic [DATA_W:0] sum_sat = sat_f(is_dsub ? raw_dif : raw_sum);
  wire logic ev_sat = (is_dadd || is_dsub) && (dbl_sat[DATA_W] || sum_sat[DATA_W]);

  // Register decode
  wire logic wr_flags = reg_wr && (reg_addr == OFF_FLAGS);
  wire logic wr_status = reg_wr && (reg_addr == OFF_IRQ_STATUS);
  wire logic wr_mask = reg_wr && (reg_addr == OFF_IRQ_MASK);
  wire logic [EV_W-1:0] ev_now = {ev_badlen, ev_sat};

  wire logic [DATA_W-1:0] rd_mux =
    (reg_addr == OFF_FLAGS) ? {30'h0, sat_q, carry_q} :
    (reg_addr == OFF_IRQ_STATUS) ? {30'h0, irq_status_q} :
    (reg_addr == OFF_IRQ_MASK) ? {30'h0, irq_mask_q} :
    (reg_addr == OFF_LAST_RESULT) ? last_result_q : 32'h0;

  // Hardware updates win over a software write in the same cycle
  always_comb begin
    carry_d = carry_q;
    sat_d = sat_q;
    if (wr_flags) begin
      carry_d = reg_wdata[FLAG_CARRY_BIT];
      sat_d = reg_wdata[FLAG_SAT_BIT];
    end
    if (carry_wr_hw) begin
      carry_d = sh_carry;
    end
    if (ev_sat) begin
      sat_d = 1'b1;
    end
  end

  always_comb begin
    irq_status_d = irq_status_q;
    if (wr_status) begin
      irq_status_d = irq_status_q & ~reg_wdata[EV_W-1:0];
    end
    irq_status_d = irq_status_d | ev_now;
  end

  always_comb begin
    rsp_d = '0;
    rsp_d.valid = req.valid;
    if (is_shift) begin
      rsp_d.data = sh_res;
      rsp_d.dest_we = req.standalone;
      rsp_d.operand_valid = !req.standalone;
    end else if (is_dadd || is_dsub) begin
      rsp_d.data = sum_sat[DATA_W-1:0];
      rsp_d.dest_we = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      carry_q <= FLAGS_RST[FLAG_CARRY_BIT];
      sat_q <= FLAGS_RST[FLAG_SAT_BIT];
    end else begin
      carry_q <= carry_d;
      sat_q <= sat_d;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_status_q <= IRQ_STATUS_RST;
      irq_mask_q <= IRQ_MASK_RST;
    end else begin
      irq_status_q <= irq_status_d;
      if (wr_mask) begin
        irq_mask_q <= reg_wdata[EV_W-1:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rsp_q <= '0;
      last_result_q <= '0;
    end else begin
      rsp_q <= rsp_d;
      if (req.valid) begin
        last_result_q <= rsp_d.data;
      end
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= reg_rd ? rd_mux : 32'h0;
    end
  end

  assign rsp = rsp_q;
  assign program_status_flags = {sat_q, carry_q};
  assign reg_rdata = rdata_q;
  assign irq = |(irq_status_q & irq_mask_q);

endmodule : bsd_datapath

// ===== sim/bsd_datapath_asserts.sv
// Checker of answer timing, routing, flag and shift-result relations
`timescale 1ns/1ps
module bsd_datapath_asserts (
  input wire logic clk,
  input wire logic rst,
  input wire bsd_pkg::bsd_req_s req,
  input wire bsd_pkg::bsd_rsp_s rsp,
  input wire logic [1:0] program_status_flags,
  input wire logic [bsd_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [bsd_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [bsd_pkg::DATA_W-1:0] reg_rdata,
  input wire logic irq
);
  import bsd_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire sh = req.valid && req.op == BSD_OP_SHIFT;
  // A software write to the flags may legally move either flag
  wire fl_wr = reg_wr && reg_addr == OFF_FLAGS;
  property p_answer;
    req.valid |=> rsp.valid;
  endproperty
  a_answer: assert property (p_answer) else $error("no answer after request");
  property p_quiet;
    !req.valid |=> !rsp.valid && !rsp.dest_we;
  endproperty
  a_quiet: assert property (p_quiet) else $error("answer without request");
  property p_route;
    sh |=> rsp.dest_we == $past(req.standalone) && rsp.operand_valid == !$past(req.standalone);
  endproperty
  a_route: assert property (p_route) else $error("shift result sent the wrong way");
  property p_pass;
    sh && req.shift_type != BSD_SH_RRX && req.shift_len == 8'h00 && !fl_wr
      |=> rsp.data == $past(req.src_a) && $stable(program_status_flags[0]);
  endproperty
  a_pass: assert property (p_pass) else $error("zero shift altered value or carry");
  property p_sign;
    sh && req.shift_type == BSD_SH_ASR && req.shift_len != 8'h00
      |=> rsp.data[31] == $past(req.src_a[31]);
  endproperty
  a_sign: assert property (p_sign) else $error("arithmetic shift lost sign");
  property p_lsr_top;
    sh && req.shift_type == BSD_SH_LSR && req.shift_len != 8'h00 |=> !rsp.data[31];
  endproperty
  a_lsr_top: assert property (p_lsr_top) else $error("logical shift top bit set");
  property p_rrx;
    sh && req.shift_type == BSD_SH_RRX && req.set_flags && !fl_wr
      |=> rsp.data == {$past(program_status_flags[0]), $past(req.src_a[31:1])}
      && program_status_flags[0] == $past(req.src_a[0]);
  endproperty
  a_rrx: assert property (p_rrx) else $error("extend rotate wrong");
  property p_sat_hold;
    program_status_flags[1] && !fl_wr |=> program_status_flags[1];
  endproperty
  a_sat_hold: assert property (p_sat_hold) else $error("sticky saturation dropped");
  property p_carry_hold;
    !(sh && req.set_flags) && !fl_wr |=> $stable(program_status_flags[0]);
  endproperty
  a_carry_hold: assert property (p_carry_hold) else $error("carry moved without shift");
endmodule : bsd_datapath_asserts

bind bsd_datapath bsd_datapath_asserts chk_u (.clk(clk), .rst(rst), .req(req), .rsp(rsp),
  .program_status_flags(program_status_flags), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));

// ===== sim/bsd_regfile_model.sv
// Register-file stand-in keeping destination writes apart from operand hand-offs
`timescale 1ns/1ps
module bsd_regfile_model (
  input wire logic clk,
  input wire logic rst,
  input wire bsd_pkg::bsd_rsp_s rsp,
  output logic [bsd_pkg::DATA_W-1:0] dest_q,
  output logic [bsd_pkg::DATA_W-1:0] operand_q
);
  import bsd_pkg::*;
  // Stack and program pointers are never named as operands here
  always_ff @(posedge clk) begin
    if (rst) begin
      dest_q <= '0;
      operand_q <= '0;
    end else begin
      if (rsp.valid && rsp.dest_we) dest_q <= rsp.data;
      if (rsp.valid && rsp.operand_valid) operand_q <= rsp.data;
    end
  end
endmodule : bsd_regfile_model

// ===== sim/bsd_datapath_tb.sv
// Self-checking bench for the shifter and saturating double-add datapath
`timescale 1ns/1ps
module bsd_datapath_tb;
  import bsd_pkg::*;
  typedef struct {
    bsd_op_e op;
    bsd_shift_e sh;
    logic [7:0] len;
    logic sf;
    logic sa;
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] d;
    logic c;
  } bsd_row_s;
  logic clk, rst, reg_wr, reg_rd, irq;
  bsd_req_s req;
  bsd_rsp_s rsp;
  logic [1:0] program_status_flags;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, dest_q, operand_q;
  int err_count = 0;
  int n_compared = 0;
  // Length 40 is an illegal immediate on purpose; it must still execute
  bsd_row_s rows[13] = '{
    '{BSD_OP_SHIFT, BSD_SH_ASR, 3, 1, 1, 32'hFFFFFFF0, 0, 32'hFFFFFFFE, 0},
    '{BSD_OP_SHIFT, BSD_SH_ASR, 32, 1, 0, 32'h80000000, 0, 32'hFFFFFFFF, 1},
    '{BSD_OP_SHIFT, BSD_SH_ASR, 40, 1, 1, 32'h40000000, 0, 32'h00000000, 0},
    '{BSD_OP_SHIFT, BSD_SH_LSR, 4, 1, 1, 32'h8000000F, 0, 32'h08000000, 1},
    '{BSD_OP_SHIFT, BSD_SH_LSR, 32, 1, 1, 32'h80000000, 0, 32'h00000000, 1},
    '{BSD_OP_SHIFT, BSD_SH_LSL, 4, 1, 0, 32'hF0000001, 0, 32'h00000010, 1},
    '{BSD_OP_SHIFT, BSD_SH_LSL, 0, 1, 1, 32'h12345678, 0, 32'h12345678, 1},
    '{BSD_OP_SHIFT, BSD_SH_ROR, 8, 1, 1, 32'h00000024, 0, 32'h24000000, 0},
    '{BSD_OP_SHIFT, BSD_SH_RRX, 0, 1, 1, 32'h00000003, 0, 32'h00000001, 1},
    '{BSD_OP_SHIFT, BSD_SH_RRX, 0, 1, 1, 32'h00000002, 0, 32'h80000001, 0},
    '{BSD_OP_SHIFT, BSD_SH_LSR, 1, 0, 1, 32'h00000001, 0, 32'h00000000, 0},
    '{BSD_OP_DADD, BSD_SH_LSL, 0, 0, 1, 32'h00000001, 32'h00000002, 32'h00000005, 0},
    '{BSD_OP_DSUB, BSD_SH_LSL, 0, 0, 1, 32'h00000010, 32'h00000003, 32'h0000000A, 0}};
  bsd_row_s sat_rows[3] = '{
    '{BSD_OP_DADD, BSD_SH_LSL, 0, 0, 1, 32'h7FFFFFFF, 32'h00000001, 32'h7FFFFFFF, 0},
    '{BSD_OP_DADD, BSD_SH_LSL, 0, 0, 1, 32'h00000000, 32'h40000000, 32'h7FFFFFFF, 0},
    '{BSD_OP_DSUB, BSD_SH_LSL, 0, 0, 1, 32'h80000000, 32'h00000001, 32'h80000000, 0}};
  bsd_row_s lsl_bad = '{BSD_OP_SHIFT, BSD_SH_LSL, 32, 1, 1, 32'h00000001, 0, 32'h0, 1};

  bsd_datapath dut_u (.clk(clk), .rst(rst), .req(req), .rsp(rsp),
    .program_status_flags(program_status_flags), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
  bsd_regfile_model rf_u (.clk(clk), .rst(rst), .rsp(rsp), .dest_q(dest_q),
    .operand_q(operand_q));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk

  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : report_and_stop

  task automatic run(input bsd_row_s r);
    @(posedge clk);
    req <= '{1'b1, r.op, r.sh, r.len, 1'b1, r.sf, r.sa, r.a, r.b};
    @(posedge clk);
    req.valid <= 1'b0;
    #1;
    chk(rsp.data, r.d);
    chk(program_status_flags[0], r.c);
    chk({rsp.valid, rsp.dest_we}, {1'b1, r.op != BSD_OP_SHIFT || r.sa});
    @(posedge clk);
    #1;
    chk(r.op == BSD_OP_SHIFT && !r.sa ? operand_q : dest_q, r.d);
  endtask : run

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask : rd

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    report_and_stop();
  end

  initial begin
    rst = 1'b1;
    req = '0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk({program_status_flags, irq, rsp.valid}, 4'h0);
    $display("test reset done");
    foreach (rows[i]) run(rows[i]);
    rd(OFF_FLAGS, 32'h0);
    rd(OFF_IRQ_STATUS, 32'h2);
    $display("test rows done");
    wr(OFF_IRQ_STATUS, 32'h3);
    run(rows[1]);
    rd(OFF_IRQ_STATUS, 32'h0);
    run(lsl_bad);
    rd(OFF_IRQ_STATUS, 32'h2);
    $display("test length limits done");
    foreach (sat_rows[i]) begin
      wr(OFF_FLAGS, 32'h0);
      wr(OFF_IRQ_STATUS, 32'h3);
      run(sat_rows[i]);
      rd(OFF_FLAGS, 32'h2);
      rd(OFF_IRQ_STATUS, 32'h1);
    end
    rd(OFF_LAST_RESULT, 32'h80000000);
    rd(8'h10, 32'h0);
    $display("test saturation done");
    wr(OFF_IRQ_MASK, 32'h1);
    chk(irq, 1'b1);
    wr(OFF_IRQ_MASK, 32'h0);
    chk(irq, 1'b0);
    wr(OFF_IRQ_MASK, 32'h1);
    wr(OFF_IRQ_STATUS, 32'h1);
    chk(irq, 1'b0);
    $display("test interrupt done");
    report_and_stop();
  end
endmodule : bsd_datapath_tb
